// *** hdl/usu_regs.svh ***
`ifndef USU_REGS_SVH
`define USU_REGS_SVH

// Shift register and edge counter widths
`define USU_DATA_W 8
`define USU_CNT_W 4

// Counter values
`define USU_CNT_MAX 4'hF
`define USU_CNT_ZERO 4'h0
`define USU_CNT_ONE 4'h1

// Serial line bit positions
`define USU_MSB 7

// Wire mode codes
`define USU_WM_OFF 2'h0
`define USU_WM_THREE 2'h1
`define USU_WM_TWO 2'h2

// Shift clock source codes
`define USU_CS_SOFT 2'h0
`define USU_CS_TIMER 2'h1
`define USU_CS_EXT 2'h2

`endif

// *** hdl/usu_pkg.sv ***
`include "usu_regs.svh"

package usu_pkg;

  typedef enum logic [1:0] {
    WM_OFF = 2'b00,
    WM_THREE = 2'b01,
    WM_TWO = 2'b10
  } usu_wire_e;

  typedef enum logic [1:0] {
    CS_SOFT = 2'b00,
    CS_TIMER = 2'b01,
    CS_EXT = 2'b10
  } usu_clk_src_e;

  typedef struct packed {
    logic si_s1;
    logic si_s2;
    logic ck_s1;
    logic ck_s2;
    logic ck_prev;
    logic sda_prev;
    logic [`USU_DATA_W-1:0] shreg;
    logic out_latch;
    logic [`USU_CNT_W-1:0] cnt;
    logic ovf;
    logic start;
    logic hold;
    logic ck_drv;
    logic ovf_irq;
    logic start_irq;
    logic wake_idle;
    logic wake_deep;
    logic data_out;
    logic sda_oe;
    logic scl_out;
    logic scl_oe;
  } usu_state_s;

endpackage : usu_pkg

// *** hdl/usu_top.sv ***
// Functional notes
// R1: Eight-bit shift register holds in and out bits, processor reads and writes it.
// R2: No receive buffer; next transfer overwrites received bits.
// R3: Shift register MSB drives one of two pins chosen by wire mode.
// R4: Transparent latch delays output change to edge opposite the sampling edge; only with external clock, else always open.
// R5: Serial input always sampled from the serial input pin.
// R6: Four-bit counter, processor readable and writable, raises overflow interrupt.
// R7: Shift register and counter advance together on the selected clock.
// R8: With external clock, counter counts both clock edges.
// R9: Shift clock from clock pin, timer zero match, or software strobe.
// R10: Two-wire mode detects start condition and can raise an interrupt.
// R11: Two-wire mode holds clock low after start or counter overflow.
// R12: Wakes from idle; in two-wire mode wakes from every sleep mode.
// R13: Three-wire and two-wire modes, each as master or slave.
// R14: Eight clock pulses give sixteen edges; counter overflows marking completion.
// R15: Edge select zero samples rising, shifts falling; one swaps them.
// R16: Counter wraps fifteen to zero and sets sticky overflow flag.
`timescale 1ns/10ps
`include "usu_regs.svh"

module usu_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [1:0] wire_mode,
  input wire logic [1:0] clock_source,
  input wire logic clock_edge_select,
  input wire logic soft_strobe,
  input wire logic timer0_match,
  input wire logic clock_toggle,
  input wire logic clock_drive_en,
  input wire logic data_drive_en,
  input wire logic start_hold_en,
  input wire logic ovf_hold_en,
  input wire logic ovf_irq_en,
  input wire logic start_irq_en,
  input wire logic data_wr,
  input wire logic [`USU_DATA_W-1:0] data_wdata,
  input wire logic count_wr,
  input wire logic [`USU_CNT_W-1:0] count_wdata,
  input wire logic ovf_clr,
  input wire logic start_clr,
  input wire logic serial_in_pin,
  input wire logic serial_clock_pin,
  output logic [`USU_DATA_W-1:0] shift_data_register,
  output logic [`USU_CNT_W-1:0] count,
  output logic counter_overflow_flag,
  output logic start_flag,
  output logic ovf_irq,
  output logic start_irq,
  output logic wake_idle,
  output logic wake_deep,
  output logic data_out,
  output logic sda_out,
  output logic sda_oe,
  output logic scl_out,
  output logic scl_oe
);

  usu_pkg::usu_state_s st_q;
  usu_pkg::usu_state_s st_d;

  logic mode_two;
  logic mode_three;
  logic src_ext;
  logic ck_rise;
  logic ck_fall;
  logic sample_edge;
  logic shift_evt;
  logic cnt_evt;
  logic ovf_evt;
  logic start_det;
  logic latch_open;

  function automatic logic edge_of(input logic prev, input logic cur, input logic rising);
    edge_of = rising ? (cur & ~prev) : (~cur & prev);
  endfunction : edge_of

  // Mode decode; master or slave is only a matter of who drives the clock
  assign mode_two = (wire_mode == usu_pkg::WM_TWO); // R13
  assign mode_three = (wire_mode == usu_pkg::WM_THREE); // R13
  assign src_ext = (clock_source == usu_pkg::CS_EXT);

  assign ck_rise = edge_of(st_q.ck_prev, st_q.ck_s2, 1'b1);
  assign ck_fall = edge_of(st_q.ck_prev, st_q.ck_s2, 1'b0);
  assign sample_edge = clock_edge_select ? ck_fall : ck_rise; // R15

  // One clock event drives both the shift register and the counter
  always_comb begin
    case (clock_source)
      usu_pkg::CS_SOFT: shift_evt = soft_strobe; // R9
      usu_pkg::CS_TIMER: shift_evt = timer0_match; // R9
      usu_pkg::CS_EXT: shift_evt = sample_edge; // R9
      default: shift_evt = 1'b0;
    endcase
  end

  // External clock counts both edges, so a byte takes sixteen counts
  assign cnt_evt = src_ext ? (ck_rise | ck_fall) : shift_evt; // R7 R8 R14
  assign ovf_evt = cnt_evt & (st_q.cnt == `USU_CNT_MAX); // R6 R14

  // Start condition: data falls while the clock is high
  assign start_det = mode_two & st_q.ck_s2 & st_q.sda_prev & ~st_q.si_s2; // R10

  // With the external clock the latch follows the MSB only while the clock sits at its pre-sample level; with other sources it is always open
  assign latch_open = src_ext ? (st_q.ck_s2 == clock_edge_select) : 1'b1; // R4 R15

  always_comb begin
    st_d = st_q;

    st_d.si_s1 = serial_in_pin;
    st_d.si_s2 = st_q.si_s1;
    st_d.ck_s1 = serial_clock_pin;
    st_d.ck_s2 = st_q.ck_s1;
    st_d.ck_prev = st_q.ck_s2;
    st_d.sda_prev = st_q.si_s2;

    // Received bits live only here and are overwritten by the next shift
    if (data_wr) begin
      st_d.shreg = data_wdata; // R1
    end else if (shift_evt) begin
      st_d.shreg = {st_q.shreg[`USU_MSB-1:0], st_q.si_s2}; // R1 R2 R5 R7
    end

    if (latch_open) begin
      st_d.out_latch = st_d.shreg[`USU_MSB]; // R4
    end

    if (count_wr) begin
      st_d.cnt = count_wdata; // R6
    end else if (cnt_evt) begin
      st_d.cnt = st_q.cnt + `USU_CNT_ONE; // R6 R16
    end

    // Hardware set wins over a clear in the same cycle
    if (ovf_evt) begin
      st_d.ovf = 1'b1; // R16
    end else if (ovf_clr) begin
      st_d.ovf = 1'b0;
    end

    if (start_det) begin
      st_d.start = 1'b1; // R10
    end else if (start_clr) begin
      st_d.start = 1'b0;
    end

    // Stretching lasts until software clears both the start and the overflow flag, or the mode leaves two-wire
    if (mode_two & ((start_det & start_hold_en) | (ovf_evt & ovf_hold_en))) begin
      st_d.hold = 1'b1; // R11
    end else if (~mode_two | ~(st_d.start | st_d.ovf)) begin
      st_d.hold = 1'b0;
    end

    if (clock_toggle) begin
      st_d.ck_drv = ~st_q.ck_drv;
    end

    st_d.ovf_irq = st_d.ovf & ovf_irq_en; // R6
    st_d.start_irq = st_d.start & start_irq_en; // R10
    st_d.wake_idle = st_d.ovf_irq | st_d.start_irq; // R12
    // Start detection needs no running serial clock, so it may wake deep sleep
    st_d.wake_deep = mode_two & (st_d.start_irq | st_d.ovf_irq); // R12

    st_d.data_out = mode_three & st_d.out_latch; // R3
    st_d.sda_oe = mode_two & data_drive_en & ~st_d.out_latch; // R3

    // Two-wire clock is open drain; three-wire master drives both levels
    if (mode_two) begin
      st_d.scl_oe = st_d.hold | (clock_drive_en & ~st_d.ck_drv); // R11
      st_d.scl_out = 1'b0;
    end else begin
      st_d.scl_oe = mode_three & clock_drive_en;
      st_d.scl_out = st_d.ck_drv;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign shift_data_register = st_q.shreg;
  assign count = st_q.cnt;
  assign counter_overflow_flag = st_q.ovf;
  assign start_flag = st_q.start;
  assign ovf_irq = st_q.ovf_irq;
  assign start_irq = st_q.start_irq;
  assign wake_idle = st_q.wake_idle;
  assign wake_deep = st_q.wake_deep;
  assign data_out = st_q.data_out;
  assign sda_out = st_q.out_latch;
  assign sda_oe = st_q.sda_oe;
  assign scl_out = st_q.scl_out;
  assign scl_oe = st_q.scl_oe;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  a_ovf_wraps: assert property ( // R16
    (ovf_evt && !count_wr) |=> (st_q.cnt == `USU_CNT_ZERO) && st_q.ovf
  ) else $error("counter did not wrap and flag overflow");

  a_flag_sticky: assert property ( // R16
    (st_q.ovf && !ovf_clr) |=> st_q.ovf
  ) else $error("overflow flag dropped without clear");

  a_set_wins: assert property ( // R16
    (ovf_clr && ovf_evt) |=> st_q.ovf
  ) else $error("overflow lost against clear");

  a_shift_input: assert property ( // R5
    (shift_evt && !data_wr) |=>
      st_q.shreg == {$past(st_q.shreg[`USU_MSB-1:0]), $past(st_q.si_s2)}
  ) else $error("shift register did not take serial input");

  a_ext_both_edges: assert property ( // R8
    (src_ext && ck_fall && !count_wr && st_q.cnt != `USU_CNT_MAX) |=>
      st_q.cnt == $past(st_q.cnt) + `USU_CNT_ONE
  ) else $error("external falling edge not counted");

  a_latch_closed: assert property ( // R4
    (src_ext && st_q.ck_s2 != clock_edge_select) |=> $stable(st_q.out_latch)
  ) else $error("output latch changed while closed");

  a_start_seen: assert property ( // R10
    start_det |=> st_q.start ##0 (st_q.start_irq == start_irq_en)
  ) else $error("start condition missed");

  a_hold_scl: assert property ( // R11
    (start_det && start_hold_en) |=> scl_oe && !scl_out
  ) else $error("clock not held low after start");

  a_pin_select: assert property ( // R3
    (!mode_three) |=> !data_out
  ) else $error("three-wire data pin driven in other mode");

  a_wake_idle: assert property ( // R12
    (ovf_irq || start_irq) |-> wake_idle
  ) else $error("interrupt without idle wake");

  a_load_data: assert property ( // R1
    data_wr |=> st_q.shreg == $past(data_wdata)
  ) else $error("shift register write lost");

  a_load_count: assert property ( // R6
    count_wr |=> st_q.cnt == $past(count_wdata)
  ) else $error("counter write lost");

  a_count_step: assert property ( // R7
    (cnt_evt && !count_wr) |=> st_q.cnt == $past(st_q.cnt) + `USU_CNT_ONE
  ) else $error("counter did not advance on its clock");

  a_shift_with_count: assert property ( // R7
    shift_evt |-> cnt_evt
  ) else $error("shift without a counter step");

  a_soft_source: assert property ( // R9
    (clock_source == usu_pkg::CS_SOFT && !soft_strobe && !data_wr) |=> $stable(st_q.shreg)
  ) else $error("shift without software strobe");

  a_timer_source: assert property ( // R9
    (clock_source == usu_pkg::CS_TIMER && timer0_match && !data_wr) |=>
      st_q.shreg[0] == $past(st_q.si_s2)
  ) else $error("timer match did not shift");

  a_ovf_clear: assert property ( // R16
    (ovf_clr && !ovf_evt) |=> !st_q.ovf
  ) else $error("overflow flag not cleared");

  a_irq_level: assert property ( // R6
    (st_q.ovf && !ovf_clr && ovf_irq_en) |=> ovf_irq
  ) else $error("overflow interrupt missing");

  a_start_clear: assert property ( // R10
    (start_clr && !start_det) |=> !st_q.start
  ) else $error("start flag not cleared");

  a_hold_ovf: assert property ( // R11
    (mode_two && ovf_evt && ovf_hold_en) |=> scl_oe && !scl_out
  ) else $error("clock not held low after overflow");

  a_hold_off: assert property ( // R11
    (!mode_two) |=> !st_q.hold
  ) else $error("clock hold outside two-wire mode");

  a_deep_two_only: assert property ( // R12
    (!mode_two) |=> !wake_deep
  ) else $error("deep wake outside two-wire mode");

  a_sample_rise: assert property ( // R15
    (src_ext && !clock_edge_select && ck_fall && !data_wr) |=> $stable(st_q.shreg)
  ) else $error("sampled on the wrong edge");

  a_sample_fall: assert property ( // R15
    (src_ext && clock_edge_select && ck_fall && !data_wr) |=>
      st_q.shreg[0] == $past(st_q.si_s2)
  ) else $error("swapped edge did not sample");

  a_no_early_ovf: assert property ( // R14
    (st_q.cnt != `USU_CNT_MAX && !st_q.ovf) |=> !st_q.ovf
  ) else $error("overflow before the last edge");

  a_data_pin_three: assert property ( // R3
    mode_three |=> data_out == st_q.out_latch
  ) else $error("three-wire data pin not following latch");

  a_sda_release: assert property ( // R3
    (mode_two && data_drive_en) |=> sda_oe == !sda_out
  ) else $error("two-wire data pin drive wrong");

  a_master_clk: assert property ( // R13
    (mode_three && clock_drive_en) |=> scl_oe && (scl_out == st_q.ck_drv)
  ) else $error("three-wire master clock not driven");

  a_latch_follow: assert property ( // R4
    latch_open |=> st_q.out_latch == st_q.shreg[`USU_MSB]
  ) else $error("open latch not following the MSB");

endmodule : usu_top

// *** sim/usu_peer.sv ***
`timescale 1ns/10ps

module usu_peer (
  input wire logic go,
  input wire logic slow,
  input wire logic swap,
  input wire logic [7:0] tx,
  input wire logic miso,
  output logic sck,
  output logic mosi,
  output logic [7:0] rx,
  output logic busy
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    rx = 8'h00;
    busy = 1'b0;
  end

  // Clock idles low between frames; a byte is eight full pulses
  always @(posedge go) begin
    busy = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      // With swapped edges data changes on the rise and is taken on the fall
      if (!swap) mosi = tx[i];
      #(slow ? 160 : 80) sck = 1'b1;
      if (swap) mosi = tx[i];
      else rx = {rx[6:0], miso};
      #(slow ? 160 : 80) sck = 1'b0;
      if (swap) rx = {rx[6:0], miso};
    end
    // Released line must not keep looking like valid data
    #80 mosi = ~mosi;
    busy = 1'b0;
  end
endmodule : usu_peer

// *** sim/universal_serial_shift_unit_test.sv ***
`timescale 1ns/10ps
`include "usu_regs.svh"

module universal_serial_shift_unit_test;
  logic ref_clk = 1'b0, sys_rst = 1'b1, clock_edge_select = 1'b0;
  logic [1:0] wire_mode = 2'h0, clock_source = 2'h0;
  logic soft_strobe = 1'b0, timer0_match = 1'b0, data_wr = 1'b0, count_wr = 1'b0;
  logic ovf_clr = 1'b0, start_clr = 1'b0, ovf_irq_en = 1'b0, start_hold_en = 1'b0;
  logic clock_toggle = 1'b0, clock_drive_en = 1'b0, data_drive_en = 1'b0;
  logic ovf_hold_en = 1'b0, start_irq_en = 1'b0;
  logic go = 1'b0, slow = 1'b0, own = 1'b1, si = 1'b1, ck = 1'b1, busy, p_sck, p_mosi;
  logic [7:0] data_wdata = 8'h00, ptx = 8'h00, rx, shift_data_register;
  logic [3:0] count_wdata = 4'h0, count;
  logic counter_overflow_flag, start_flag, ovf_irq, start_irq, wake_idle, wake_deep;
  logic data_out, sda_out, sda_oe, scl_out, scl_oe;
  int err_count = 0, checks = 0;
  // Open-drain wires: a driving device can only pull low
  wire sda = (own ? si : p_mosi) & ~(sda_oe & ~sda_out);
  wire scl = (own ? ck : p_sck) & ~(scl_oe & ~scl_out);

  always #5 ref_clk = ~ref_clk;

  usu_top dut (.ref_clk, .sys_rst, .wire_mode, .clock_source, .clock_edge_select,
    .soft_strobe, .timer0_match, .clock_toggle, .clock_drive_en,
    .data_drive_en, .start_hold_en, .ovf_hold_en, .ovf_irq_en,
    .start_irq_en, .data_wr, .data_wdata, .count_wr, .count_wdata, .ovf_clr,
    .start_clr, .serial_in_pin(sda), .serial_clock_pin(scl), .shift_data_register, .count,
    .counter_overflow_flag, .start_flag, .ovf_irq, .start_irq, .wake_idle, .wake_deep,
    .data_out, .sda_out, .sda_oe, .scl_out, .scl_oe);

  usu_peer peer (.go, .slow, .swap(clock_edge_select), .tx(ptx), .miso(data_out),
    .sck(p_sck), .mosi(p_mosi), .rx, .busy);

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task automatic load(input logic [7:0] d, input logic [3:0] c);
    data_wr = 1'b1;
    data_wdata = d;
    count_wr = 1'b1;
    count_wdata = c;
    ovf_clr = 1'b1;
    start_clr = 1'b1;
    tick(1);
    {data_wr, count_wr, ovf_clr, start_clr} = 4'h0;
    tick(2);
  endtask : load

  task automatic t_reset;
    chk(shift_data_register, 8'h00);
    chk(count, 4'h0);
    chk(counter_overflow_flag, 1'b0);
    chk(start_flag, 1'b0);
    chk(scl_oe, 1'b0);
    chk(sda_oe, 1'b0);
    chk(wake_idle, 1'b0);
  endtask : t_reset

  // Reset in mid-run must bring the state back to its idle values
  task automatic t_reset_mid;
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    tick(1);
    t_reset();
  endtask : t_reset_mid

  // Counter loaded at its top value, one strobe from each internal source
  task automatic t_strobe;
    ovf_irq_en = 1'b1;
    for (int src = 0; src < 2; src++) begin
      load(8'hA5, 4'hF);
      clock_source = src[1:0];
      soft_strobe = (src == 0);
      timer0_match = (src == 1);
      tick(1);
      {soft_strobe, timer0_match} = 2'h0;
      tick(2);
      chk(shift_data_register, 8'h4B);
      chk(count, 4'h0);
      chk(counter_overflow_flag, 1'b1);
      chk(ovf_irq, 1'b1);
      chk(wake_idle, 1'b1);
      tick(5);
      chk(counter_overflow_flag, 1'b1);
    end
    ovf_clr = 1'b1;
    tick(1);
    ovf_clr = 1'b0;
    tick(2);
    chk(counter_overflow_flag, 1'b0);
  endtask : t_strobe

  // Three external-clock bytes: fast, half speed, then with the edges swapped
  task automatic t_xfer;
    logic [7:0] mine;
    own = 1'b0;
    wire_mode = `USU_WM_THREE;
    clock_source = `USU_CS_EXT;
    tick(6);
    for (int k = 0; k < 3; k++) begin
      slow = (k == 1);
      clock_edge_select = (k == 2);
      ptx = (k == 0) ? 8'hA5 : (k == 1) ? 8'h96 : 8'h5A;
      mine = (k == 2) ? 8'hC3 : 8'h3C;
      load(mine, 4'h0);
      go = 1'b1;
      tick(1);
      go = 1'b0;
      for (int i = 0; i < 1000 && busy; i++) tick(1);
      tick(8);
      chk(shift_data_register, ptx);
      chk(count, 4'h0);
      chk(counter_overflow_flag, 1'b1);
      chk(rx, mine);
    end
    clock_edge_select = 1'b0;
  endtask : t_xfer

  // Three-wire master: the block toggles its own clock pin for sixteen edges
  task automatic t_master;
    own = 1'b1;
    si = 1'b1;
    ck = 1'b1;
    clock_drive_en = 1'b1;
    tick(6);
    load(8'h00, 4'h0);
    for (int e = 0; e < 16; e++) begin
      clock_toggle = 1'b1;
      tick(1);
      clock_toggle = 1'b0;
      tick(5);
    end
    chk(scl_oe, 1'b1);
    chk(scl_out, 1'b0);
    chk(shift_data_register, 8'hFF);
    chk(count, 4'h0);
    chk(counter_overflow_flag, 1'b1);
    chk(wake_idle, 1'b1);
    chk(wake_deep, 1'b0);
    clock_drive_en = 1'b0;
    tick(6);
  endtask : t_master

  // Two-wire slave: start detection, clock stretching and the open-drain data pin
  task automatic t_two;
    own = 1'b1;
    wire_mode = `USU_WM_TWO;
    clock_source = `USU_CS_SOFT;
    start_hold_en = 1'b1;
    start_irq_en = 1'b1;
    tick(6);
    load(8'h00, 4'h0);
    chk(scl_oe, 1'b0);
    chk(start_irq, 1'b0);
    si = 1'b0;
    tick(7);
    chk(start_flag, 1'b1);
    chk(start_irq, 1'b1);
    chk(wake_deep, 1'b1);
    chk(scl_oe, 1'b1);
    chk(scl_out, 1'b0);
    si = 1'b1;
    load(8'h00, 4'h0);
    chk(scl_oe, 1'b0);
    chk(start_irq, 1'b0);
    chk(wake_deep, 1'b0);
    ovf_hold_en = 1'b1;
    load(8'h00, 4'hF);
    soft_strobe = 1'b1;
    tick(1);
    soft_strobe = 1'b0;
    tick(2);
    chk(counter_overflow_flag, 1'b1);
    chk(scl_oe, 1'b1);
    chk(wake_deep, 1'b1);
    ovf_clr = 1'b1;
    tick(1);
    ovf_clr = 1'b0;
    tick(2);
    chk(scl_oe, 1'b0);
    // Clock held low so that pulling the data line is no start condition
    data_drive_en = 1'b1;
    ck = 1'b0;
    load(8'h00, 4'h0);
    chk(sda_oe, 1'b1);
    chk(sda_out, 1'b0);
    chk(data_out, 1'b0);
    load(8'h80, 4'h0);
    chk(sda_oe, 1'b0);
    chk(sda_out, 1'b1);
    chk(data_out, 1'b0);
    data_drive_en = 1'b0;
    ck = 1'b1;
    tick(4);
    chk(start_flag, 1'b0);
  endtask : t_two

  initial begin
    tick(3);
    sys_rst = 1'b0;
    tick(1);
    t_reset();
    t_strobe();
    t_xfer();
    t_master();
    t_two();
    t_reset_mid();
    end_sim();
  end

  initial begin
    #200000;
    err_count++;
    end_sim();
  end
endmodule : universal_serial_shift_unit_test
